// >>> global_interrupt_aggregator.sv
// Global interrupt flag/enable register and interrupt line generation.
// Assumes individual flag/enable vectors, FIFO occupancy and wakeup
// events are supplied synchronous to sys_clk by neighbouring blocks.
//
// Functional notes
// - Module summary ORs other enabled flags
// - Module line needs summary and enable
// - Protocol summary from both enabled flag words
// - Protocol line needs summary and enable
// - Host error summary from flags and enable
// - Host error line needs summary and enable
// - Wakeup symbol sets wakeup flag
// - Wakeup line needs flag and enable
// - FIFO B not empty sets its flag
// - Write one advances FIFO B index
// - FIFO B line needs flag and enable
// - FIFO A not empty sets its flag
// - Write one advances FIFO A index
// - FIFO A line needs flag and enable
// - Receive summary from enabled receive buffers
// - Software cannot clear receive summary
// - Only wakeup and FIFO flags clearable
// - Writing zero leaves flag unchanged
// - Wakeup set wins over simultaneous clear
// - Summaries drop when sources cleared
// - Module enable bit gates module line
// - Receive enable bit gates receive line
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module global_interrupt_aggregator
  import gia_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [gia_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] protocol_flags_low,
  input wire logic [15:0] protocol_enables_low,
  input wire logic [15:0] protocol_flags_high,
  input wire logic [15:0] protocol_enables_high,
  input wire logic [15:0] host_iface_error_flags,
  input wire logic [31:0] buffer_irq_flag,
  input wire logic [31:0] buffer_irq_enable,
  input wire logic [31:0] buffer_direction,
  input wire logic transmit_buffer_summary_flag,
  input wire logic wakeup_symbol_a,
  input wire logic wakeup_symbol_b,
  input wire logic fifo_a_fill,
  input wire logic fifo_b_fill,
  output logic fifo_a_pop,
  output logic fifo_b_pop,
  output logic [gia_pkg::IDX_W-1:0] fifo_a_read_index,
  output logic [gia_pkg::IDX_W-1:0] fifo_b_read_index,
  output logic module_irq,
  output logic protocol_irq,
  output logic host_iface_error_irq,
  output logic wakeup_irq,
  output logic fifo_a_irq,
  output logic fifo_b_irq,
  output logic receive_buffer_irq,
  output logic transmit_buffer_irq
);
  import gia_pkg::*;

  logic module_irq_enable;
  logic protocol_irq_enable;
  logic host_iface_error_irq_enable;
  logic wakeup_irq_enable;
  logic fifo_b_irq_enable;
  logic fifo_a_irq_enable;
  logic receive_buffer_irq_enable;
  logic transmit_buffer_irq_enable;
  logic wakeup_flag;
  logic fifo_a_not_empty_flag;
  logic fifo_b_not_empty_flag;
  logic wakeup_seen_channel_a;
  logic wakeup_seen_channel_b;
  logic module_summary_flag;
  logic protocol_summary_flag;
  logic host_iface_error_summary_flag;
  logic receive_buffer_summary_flag;
  logic [15:0] global_interrupt_flags_enables;
  logic global_wr;
  logic clr_wakeup;
  logic clr_fifo_a;
  logic clr_fifo_b;

  // Read index wraps back to the window start after the last slot
  function automatic logic [IDX_W-1:0] next_index(
    input logic [IDX_W-1:0] idx
  );
    next_index = (idx == FIFO_LAST) ? FIFO_FIRST : idx + 8'h01;
  endfunction

  // Write decode for the global register clear bits
  // clear only three flags
  assign global_wr = reg_wr && (reg_addr == OFF_GLOBAL);
  assign clr_wakeup = global_wr && reg_wdata[BIT_WAKEUP];
  assign clr_fifo_a = global_wr && reg_wdata[BIT_FIFO_A];
  assign clr_fifo_b = global_wr && reg_wdata[BIT_FIFO_B];
  assign fifo_a_pop = clr_fifo_a && fifo_a_not_empty_flag;
  assign fifo_b_pop = clr_fifo_b && fifo_b_not_empty_flag;

  // Enable bits, written whole on every global register write
  // module enable stored
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      {module_irq_enable, protocol_irq_enable, host_iface_error_irq_enable,
       wakeup_irq_enable, fifo_b_irq_enable, fifo_a_irq_enable,
       receive_buffer_irq_enable, transmit_buffer_irq_enable}
        <= ENABLES_RESET;
    end
    else if (global_wr)
    begin
      {module_irq_enable, protocol_irq_enable, host_iface_error_irq_enable,
       wakeup_irq_enable, fifo_b_irq_enable, fifo_a_irq_enable,
       receive_buffer_irq_enable, transmit_buffer_irq_enable}
        <= reg_wdata[7:0];
    end
  end

  // Wakeup flag and per-channel indications; set beats clear
  // wakeup symbol sets
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wakeup_flag <= 1'b0;
    end
    else if (wakeup_symbol_a || wakeup_symbol_b)
    begin
      wakeup_flag <= 1'b1;
    end
    else if (clr_wakeup)
    begin
      wakeup_flag <= 1'b0;
    end
  end

  // Channel indications are cleared by writing one to the status word
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wakeup_seen_channel_a <= 1'b0;
      wakeup_seen_channel_b <= 1'b0;
    end
    else
    begin
      wakeup_seen_channel_a <= wakeup_symbol_a || (wakeup_seen_channel_a &&
        !(reg_wr && reg_addr == OFF_WAKE_STAT && reg_wdata[0]));
      wakeup_seen_channel_b <= wakeup_symbol_b || (wakeup_seen_channel_b &&
        !(reg_wr && reg_addr == OFF_WAKE_STAT && reg_wdata[1]));
    end
  end

  // FIFO flags follow occupancy; a pop advances the read index.
  // The flag drops for the cycle after the pop and is re-set a cycle later if the
  // FIFO still holds data, so a one-cycle gap shows on the line.
  // FIFO B fill
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      fifo_a_not_empty_flag <= 1'b0;
      fifo_b_not_empty_flag <= 1'b0;
      fifo_a_read_index <= IDX_RESET;
      fifo_b_read_index <= IDX_RESET;
    end
    else
    begin
      fifo_a_not_empty_flag <= fifo_a_fill && !fifo_a_pop;
      fifo_b_not_empty_flag <= fifo_b_fill && !fifo_b_pop;
      if (fifo_a_pop)
      begin
        fifo_a_read_index <= next_index(fifo_a_read_index);
      end
      if (fifo_b_pop)
      begin
        fifo_b_read_index <= next_index(fifo_b_read_index);
      end
    end
  end

  // Summary flags are pure ORs of flag-and-enable, so they drop by
  // themselves once software clears every source or enable
  // protocol summary
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      protocol_summary_flag <= 1'b0;
      host_iface_error_summary_flag <= 1'b0;
      receive_buffer_summary_flag <= 1'b0;
    end
    else
    begin
      protocol_summary_flag <=
        |(protocol_flags_low & protocol_enables_low) ||
        |(protocol_flags_high & protocol_enables_high);
      host_iface_error_summary_flag <=
        |host_iface_error_flags && host_iface_error_irq_enable;
      receive_buffer_summary_flag <=
        |(buffer_irq_flag & buffer_irq_enable & buffer_direction);
    end
  end

  // Module summary from the other flags with their enables
  // module summary
  assign module_summary_flag =
    (protocol_summary_flag && protocol_irq_enable) ||
    (host_iface_error_summary_flag && host_iface_error_irq_enable) ||
    (wakeup_flag && wakeup_irq_enable) ||
    (fifo_b_not_empty_flag && fifo_b_irq_enable) ||
    (fifo_a_not_empty_flag && fifo_a_irq_enable) ||
    (receive_buffer_summary_flag && receive_buffer_irq_enable) ||
    (transmit_buffer_summary_flag && transmit_buffer_irq_enable);

  // Interrupt lines registered so they are glitch-free levels
  // module line
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      module_irq <= 1'b0;
      protocol_irq <= 1'b0;
      host_iface_error_irq <= 1'b0;
      wakeup_irq <= 1'b0;
      fifo_a_irq <= 1'b0;
      fifo_b_irq <= 1'b0;
      receive_buffer_irq <= 1'b0;
      transmit_buffer_irq <= 1'b0;
    end
    else
    begin
      module_irq <= module_summary_flag && module_irq_enable;
      protocol_irq <= protocol_summary_flag && protocol_irq_enable;
      host_iface_error_irq <=
        host_iface_error_summary_flag && host_iface_error_irq_enable;
      wakeup_irq <= wakeup_flag && wakeup_irq_enable;
      fifo_a_irq <= fifo_a_not_empty_flag && fifo_a_irq_enable;
      fifo_b_irq <= fifo_b_not_empty_flag && fifo_b_irq_enable;
      receive_buffer_irq <=
        receive_buffer_summary_flag && receive_buffer_irq_enable;
      transmit_buffer_irq <=
        transmit_buffer_summary_flag && transmit_buffer_irq_enable;
    end
  end

  // Assembled view of the global register
  always_comb
  begin
    global_interrupt_flags_enables = 16'h0000;
    global_interrupt_flags_enables[BIT_MODULE] = module_summary_flag;
    global_interrupt_flags_enables[BIT_HOST_ERR] =
      host_iface_error_summary_flag;
    global_interrupt_flags_enables[BIT_PROTOCOL] = protocol_summary_flag;
    global_interrupt_flags_enables[BIT_WAKEUP] = wakeup_flag;
    global_interrupt_flags_enables[BIT_FIFO_B] = fifo_b_not_empty_flag;
    global_interrupt_flags_enables[BIT_FIFO_A] = fifo_a_not_empty_flag;
    global_interrupt_flags_enables[BIT_RX_BUF] = receive_buffer_summary_flag;
    global_interrupt_flags_enables[BIT_TX_BUF] = transmit_buffer_summary_flag;
    global_interrupt_flags_enables[7:0] = {module_irq_enable,
      protocol_irq_enable, host_iface_error_irq_enable, wakeup_irq_enable,
      fifo_b_irq_enable, fifo_a_irq_enable, receive_buffer_irq_enable,
      transmit_buffer_irq_enable};
  end

  // Read data stands the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        OFF_GLOBAL: reg_rdata <= global_interrupt_flags_enables;
        OFF_FIFO_A_IDX: reg_rdata <= {8'h00, fifo_a_read_index};
        OFF_FIFO_B_IDX: reg_rdata <= {8'h00, fifo_b_read_index};
        OFF_WAKE_STAT: reg_rdata <=
          {14'h0000, wakeup_seen_channel_b, wakeup_seen_channel_a};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
    begin
      reg_rdata <= 16'h0000;
    end
  end

  // Wakeup event on either channel in a clear cycle leaves the flag set
  a_wakeup_set_wins: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ((wakeup_symbol_a || wakeup_symbol_b) && clr_wakeup) |=> wakeup_flag)
    else $error("wakeup flag lost on simultaneous clear");

  // Zero write does not clear the wakeup flag
  a_zero_write_keeps: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (global_wr && !reg_wdata[BIT_WAKEUP] && wakeup_flag) |=> wakeup_flag)
    else $error("wakeup flag cleared by zero write");

  // Module line follows summary and enable one cycle later
  a_module_line: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    module_irq == $past(module_summary_flag && module_irq_enable))
    else $error("module line mismatch");

  // Host error line follows its summary and enable
  a_host_err_line: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    host_iface_error_irq ==
      $past(host_iface_error_summary_flag && host_iface_error_irq_enable))
    else $error("host error line mismatch");

  // FIFO A line follows its flag and enable
  a_fifo_a_line: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fifo_a_irq == $past(fifo_a_not_empty_flag && fifo_a_irq_enable))
    else $error("FIFO A line mismatch");

  // FIFO B line follows its flag and enable
  a_fifo_b_line: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fifo_b_irq == $past(fifo_b_not_empty_flag && fifo_b_irq_enable))
    else $error("FIFO B line mismatch");

  // A pop moves the FIFO A read index by one slot, wrapping at the end
  a_fifo_a_pop_idx: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fifo_a_pop |=> fifo_a_read_index == next_index($past(fifo_a_read_index)))
    else $error("FIFO A index not advanced");

  // FIFO B flag comes back after a pop while data remain
  a_fifo_b_refill: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (fifo_b_pop && fifo_b_fill) ##1 fifo_b_fill |=> fifo_b_not_empty_flag)
    else $error("FIFO B flag not set again");

  // Receive line stays low while its enable is low
  a_rx_summary_line: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !receive_buffer_irq_enable ##1 !receive_buffer_irq_enable
    |=> !receive_buffer_irq)
    else $error("receive line with enable low");

  // Writing one to the receive summary bit cannot clear it
  a_rx_no_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (global_wr && reg_wdata[BIT_RX_BUF] &&
      |(buffer_irq_flag & buffer_irq_enable & buffer_direction))
    |=> receive_buffer_summary_flag)
    else $error("receive summary cleared by software");

  // Wakeup line rises one cycle after the flag when enabled
  a_wakeup_irq_line: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (wakeup_symbol_a || wakeup_symbol_b) ##1 wakeup_irq_enable |=> wakeup_irq)
    else $error("wakeup line missing");

  // Protocol summary and line drop once both flag words are clear
  a_protocol_drop: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (protocol_flags_low == 16'h0000 && protocol_flags_high == 16'h0000)
    |=> !protocol_summary_flag ##1 !protocol_irq)
    else $error("protocol summary stuck");
endmodule

// >>> gia_pkg.sv
// Package for the global interrupt aggregator: register offset, bit layout
// of the global flag/enable register, reset values and FIFO sizes.
// Assumes a 16-bit register word and a single register clock.
package gia_pkg;
  localparam int REG_ADDR_W = 4;
  localparam int IDX_W = 8;
  // Offsets (word index) of the register port
  localparam logic [3:0] OFF_GLOBAL = 4'h0;
  localparam logic [3:0] OFF_FIFO_A_IDX = 4'h1;
  localparam logic [3:0] OFF_FIFO_B_IDX = 4'h2;
  localparam logic [3:0] OFF_WAKE_STAT = 4'h3;
  // Bit positions in the global register
  localparam int BIT_MODULE = 15;
  localparam int BIT_PROTOCOL = 13;
  localparam int BIT_HOST_ERR = 14;
  localparam int BIT_WAKEUP = 12;
  localparam int BIT_FIFO_B = 11;
  localparam int BIT_FIFO_A = 10;
  localparam int BIT_RX_BUF = 9;
  localparam int BIT_TX_BUF = 8;
  localparam int BIT_MODULE_EN = 7;
  localparam int BIT_PROTOCOL_EN = 6;
  localparam int BIT_HOST_ERR_EN = 5;
  localparam int BIT_WAKEUP_EN = 4;
  localparam int BIT_FIFO_B_EN = 3;
  localparam int BIT_FIFO_A_EN = 2;
  localparam int BIT_RX_BUF_EN = 1;
  localparam int BIT_TX_BUF_EN = 0;
  // Reset values
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RESET = 8'h00;
  // Default FIFO window: read index wraps from last back to first
  localparam logic [IDX_W-1:0] FIFO_FIRST = 8'h00;
  localparam logic [IDX_W-1:0] FIFO_LAST = 8'h0F;
endpackage

// >>> rx_fifo_model.sv
// Occupancy model of one receive FIFO as the aggregator sees it.
// Assumes push and pop are one-cycle pulses sampled on sys_clk.
`timescale 1ns/1ps
module rx_fifo_model
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic pop,
  output logic fill
);
  logic [4:0] count;

  // Count moves on the pop edge, so fill lags the pop by one cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      count <= 5'h00;
    else if (push && !pop)
      count <= count + 5'h01;
    else if (pop && !push && count != 5'h00)
      count <= count - 5'h01; // Popping an empty FIFO is a no-op
  end

  // Level that says at least one entry is held
  assign fill = (count != 5'h00);
endmodule

// >>> tb.sv
// Self-checking bench for the global interrupt aggregator.
// Assumes the register port of the package and two FIFO occupancy models.
`timescale 1ns/1ps
module tb;
  import gia_pkg::*;
  logic sys_clk, sys_rst, reg_wr, reg_rd;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [15:0] protocol_flags_low, protocol_enables_low;
  logic [15:0] protocol_flags_high, protocol_enables_high;
  logic [15:0] host_iface_error_flags;
  logic [31:0] buffer_irq_flag, buffer_irq_enable, buffer_direction;
  logic transmit_buffer_summary_flag, wakeup_symbol_a, wakeup_symbol_b;
  logic fifo_a_fill, fifo_b_fill, fifo_a_pop, fifo_b_pop, push_a, push_b;
  logic [IDX_W-1:0] fifo_a_read_index, fifo_b_read_index;
  logic module_irq, protocol_irq, host_iface_error_irq, wakeup_irq;
  logic fifo_a_irq, fifo_b_irq, receive_buffer_irq, transmit_buffer_irq;
  logic [7:0] lines;
  int bad_count = 0;
  int cmp_count = 0;

  global_interrupt_aggregator u_global_interrupt_aggregator (.sys_clk,
    .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .protocol_flags_low, .protocol_enables_low, .protocol_flags_high,
    .protocol_enables_high, .host_iface_error_flags, .buffer_irq_flag,
    .buffer_irq_enable, .buffer_direction, .transmit_buffer_summary_flag,
    .wakeup_symbol_a, .wakeup_symbol_b, .fifo_a_fill, .fifo_b_fill,
    .fifo_a_pop, .fifo_b_pop, .fifo_a_read_index, .fifo_b_read_index,
    .module_irq, .protocol_irq, .host_iface_error_irq, .wakeup_irq,
    .fifo_a_irq, .fifo_b_irq, .receive_buffer_irq, .transmit_buffer_irq);
  rx_fifo_model u_fifo_a (.sys_clk, .sys_rst, .push(push_a),
    .pop(fifo_a_pop), .fill(fifo_a_fill));
  rx_fifo_model u_fifo_b (.sys_clk, .sys_rst, .push(push_b),
    .pop(fifo_b_pop), .fill(fifo_b_fill));

  // Lines in the same order as the enable bits 7..0
  assign lines = {module_irq, protocol_irq, host_iface_error_irq, wakeup_irq,
    fifo_b_irq, fifo_a_irq, receive_buffer_irq, transmit_buffer_irq};

  // Free-running 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One-cycle write strobe
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe; taken at the
  // closing edge, before the design clears them, so stimulus stays on edges
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic read_check(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    reg_read(a, v);
    check("register", v, exp);
  endtask

  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {protocol_flags_low, protocol_enables_low} = '0;
    {protocol_flags_high, protocol_enables_high} = '0;
    {host_iface_error_flags, transmit_buffer_summary_flag} = '0;
    {buffer_irq_flag, buffer_irq_enable, buffer_direction} = '0;
    {wakeup_symbol_a, wakeup_symbol_b, push_a, push_b} = '0;
    sys_rst = 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    read_check(OFF_GLOBAL, 16'h0000); // reset state
    read_check(OFF_FIFO_A_IDX, 16'h0000); // reset index
    read_check(4'hF, 16'h0000); // unmapped place
    check("lines", {8'h00, lines}, 16'h0000); // lines cleared
    // Enabled bit in the other word, host error without its enable
    protocol_flags_high <= 16'h0020;
    protocol_enables_low <= 16'h0020;
    host_iface_error_flags <= 16'h0001;
    tick(3);
    read_check(OFF_GLOBAL, 16'h0000); // no summary
    protocol_enables_high <= 16'h0020;
    tick(3);
    read_check(OFF_GLOBAL, 16'h2000); // summary set
    reg_write(OFF_GLOBAL, 16'h00C0);
    read_check(OFF_GLOBAL, 16'hA0C0); // module summary
    check("lines", {8'h00, lines}, 16'h00C0); // lines
    reg_write(OFF_GLOBAL, 16'h0040);
    read_check(OFF_GLOBAL, 16'hA040); // summary kept
    check("lines", {8'h00, lines}, 16'h0040); // module gated
    reg_write(OFF_GLOBAL, 16'h0060);
    read_check(OFF_GLOBAL, 16'hE060); // host error summary
    check("lines", {8'h00, lines}, 16'h0060); // host error line
    protocol_flags_high <= 16'h0000;
    host_iface_error_flags <= 16'h0000;
    tick(3);
    read_check(OFF_GLOBAL, 16'h0060); // sources gone
    check("lines", {8'h00, lines}, 16'h0000); // lines drop
    // Receive buffers: only receive-direction buffers count
    buffer_irq_flag <= 32'h0000_0004;
    buffer_irq_enable <= 32'h0000_0006;
    buffer_direction <= 32'h0000_0002;
    tick(3);
    read_check(OFF_GLOBAL, 16'h0060); // transmit buffer only
    buffer_direction <= 32'h0000_0004;
    tick(3);
    reg_write(OFF_GLOBAL, 16'h0282);
    read_check(OFF_GLOBAL, 16'h8282); // clear refused
    check("lines", {8'h00, lines}, 16'h0082); // receive line
    buffer_irq_enable <= 32'h0000_0000;
    tick(3);
    read_check(OFF_GLOBAL, 16'h0082); // enables cleared
    // Wakeup flag set, kept on zero write, kept when set meets clear
    reg_write(OFF_GLOBAL, 16'h0090);
    wakeup_symbol_a <= 1'b1;
    tick(1);
    wakeup_symbol_a <= 1'b0;
    tick(2);
    read_check(OFF_GLOBAL, 16'h9090); // wakeup flag
    check("lines", {8'h00, lines}, 16'h0090); // wakeup line
    read_check(OFF_WAKE_STAT, 16'h0001); // channel seen
    reg_write(OFF_GLOBAL, 16'h0090);
    read_check(OFF_GLOBAL, 16'h9090); // zero keeps flag
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= OFF_GLOBAL;
    reg_wdata <= 16'h1090;
    wakeup_symbol_b <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    wakeup_symbol_b <= 1'b0;
    read_check(OFF_GLOBAL, 16'h9090); // set wins
    reg_write(OFF_GLOBAL, 16'h1090);
    read_check(OFF_GLOBAL, 16'h0090); // cleared by one
    // FIFOs: two entries in B, sixteen in A to reach the index wrap
    reg_write(OFF_GLOBAL, 16'h000C);
    for (int i = 0; i < 16; i++)
    begin
      push_a <= 1'b1;
      push_b <= (i < 2);
      tick(1);
    end
    {push_a, push_b} <= 2'b00;
    for (int i = 0; i < 9 && fifo_a_irq !== 1'b1; i++)
    begin
      tick(1);
      if (i == 8)
      begin
        bad_count++;
        final_report();
      end
    end
    read_check(OFF_GLOBAL, 16'h8C0C); // flags set
    check("lines", {8'h00, lines}, 16'h000C); // lines
    reg_write(OFF_GLOBAL, 16'h080C);
    tick(2);
    read_check(OFF_FIFO_B_IDX, 16'h0001); // index advanced
    check("index b", {8'h00, fifo_b_read_index}, 16'h0001); // port
    read_check(OFF_GLOBAL, 16'h8C0C); // set again
    reg_write(OFF_GLOBAL, 16'h080C);
    tick(2);
    read_check(OFF_FIFO_B_IDX, 16'h0002); // second pop
    read_check(OFF_GLOBAL, 16'h840C); // cleared when empty
    for (int i = 0; i < 16; i++)
    begin
      reg_write(OFF_GLOBAL, 16'h040C);
      tick(2);
      read_check(OFF_FIFO_A_IDX, 16'((i + 1) % 16)); // wraps
      check("index a", {8'h00, fifo_a_read_index}, 16'((i + 1) % 16));
    end
    read_check(OFF_GLOBAL, 16'h000C); // cleared when empty
    check("lines", {8'h00, lines}, 16'h0000); // line drops
    reg_write(OFF_GLOBAL, 16'h040C);
    tick(2);
    read_check(OFF_FIFO_A_IDX, 16'h0000); // no pop when clear
    // Transmit summary comes from outside but still feeds bit 15
    transmit_buffer_summary_flag <= 1'b1;
    reg_write(OFF_GLOBAL, 16'h0081);
    tick(2);
    read_check(OFF_GLOBAL, 16'h8181); // transmit source
    check("lines", {8'h00, lines}, 16'h0081); // transmit line
    final_report();
  end
endmodule
